// File: inc/buck_ctl_params.svh
// Constants of the buck mode controller: timing figures, register offsets,
// field positions and reset values.
// Assumes a single 50 MHz system clock and a 32-bit APB register port.
`ifndef BUCK_CTL_PARAMS_SVH
`define BUCK_CTL_PARAMS_SVH

// System clock period
`define CLK_PERIOD_NS 20
// Oscillator cycles counted before low-quiescent entry
`define PFM_ENTRY_OSC_CYCLES 2048
// Wake-up delay after feedback drops, least time
`define PFM_WAKE_NS 2500
// Longest high-side on-time in a PFM pulse
`define PFM_MAX_ON_NS 1000
// Off delay after each PFM pulse, least time
`define PFM_OFF_NS 500
// Cycle counts derived from the times above
`define PFM_WAKE_CYC ((`PFM_WAKE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PFM_MAX_ON_CYC (`PFM_MAX_ON_NS / `CLK_PERIOD_NS)
`define PFM_OFF_CYC ((`PFM_OFF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Register byte offsets
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_IRQ_STAT 8'h08
`define REG_IRQ_MASK 8'h0c

// Control register fields and reset value
`define CTRL_PFM_ALLOW 0
`define CTRL_RESET 1'h1

// Status register fields
`define ST_MODE_LSB 0
`define ST_HS_GATE 3
`define ST_REDUCED 4
`define ST_LOWQ 5
`define ST_FAULT 6
`define ST_MODE_PIN 7

// Interrupt event bits, shared by status and mask
`define IRQ_PFM_ENTRY 0
`define IRQ_PFM_EXIT 1
`define IRQ_FAULT_FALLBACK 2
`define IRQ_PULSE_SKIP 3
`define IRQ_W 4
`define IRQ_MASK_RESET 4'h0

`endif

// File: inc/buck_ctl_pkg.sv
// Types of the buck mode controller.
// Assumes the constants header is compiled alongside.
package buck_ctl_pkg;

    // Operating states of the mode controller
    typedef enum logic [2:0] {
        ST_SHUTDOWN = 3'b000,
        ST_PWM = 3'b001,
        ST_PFM_COAST = 3'b010,
        ST_PFM_WAKE = 3'b011,
        ST_PFM_ON = 3'b100,
        ST_PFM_OFF = 3'b101,
        ST_LOWIP_PWM = 3'b110
    } mode_e;

endpackage

// File: design/sync_2ff.sv
// Two-flop synchroniser for a vector of independent asynchronous levels.
// Assumes each bit is a slow level; bits are not coherent with each other.
module sync_2ff #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Levels
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    initial begin
        if (W < 1) begin
            $error("sync_2ff: width must be at least one");
        end
    end

    // One independent two-stage chain per bit
    for (genvar i = 0; i < W; i++) begin : g_bit
        logic meta;
        always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
                meta <= 1'b0;
                sync_out[i] <= 1'b0;
            end else begin
                meta <= async_in[i];
                sync_out[i] <= meta;
            end
        end
    end

endmodule

// File: design/delay_timer.sv
// Loadable down-counter used for wake, on-time and off delays.
// Assumes load values of at least one; expired marks the last counted cycle.
module delay_timer #(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Control
    input wire logic load,
    input wire logic [W-1:0] load_val,
    // Status
    output logic expired
);

    logic [W-1:0] cnt;

    initial begin
        if (W < 2) begin
            $error("delay_timer: width must be at least two");
        end
    end

    // Load wins over counting; stop at zero
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cnt <= '0;
        end else if (load) begin
            cnt <= load_val;
        end else if (cnt != '0) begin
            cnt <= cnt - 1'b1;
        end
    end

    // Expiry depends on the count alone: the load is decoded from the state
    // change that expiry causes, so gating with load would close a loop
    assign expired = (cnt == {{(W-1){1'b0}}, 1'b1});

endmodule

// File: design/buck_mode_ctrl.sv
// Mode control of a peak-current-mode buck: PWM latch, low-quiescent PFM
// bursts, reduced-current fallback, APB registers and an interrupt.
// Assumes comparator results and mode pins arrive asynchronously and that
// the oscillator arrives as a slow level well below half the system clock.
`include "buck_ctl_params.svh"

// Contract
// - Enter PFM only after 2048 oscillator cycles with sleep, soft-start, output good high.
// - In PFM with feedback above threshold, coast with switching off and circuits low.
// - On feedback below threshold, power up, wait about 2.5 us, then switch on.
// - End a PFM pulse on peak-current trip or maximum on-time, whichever first.
// - After the off delay, pulse again if feedback low, else return to coast.
// - In PWM each oscillator edge sets the latch; the current comparator resets it.
// - Latch is reset-dominant: edges during reset are ignored, pulses skip.
// - In PWM all fault detectors stay enabled.
// - In PFM still detect diode, boot, output and switch-node faults.
// - A fault in PFM moves to reduced-current PWM at half current limit.
// - Thermal shutdown monitor is disabled in low-quiescent PFM.
// - Reduced-current PWM only on PFM request with fault; re-enable all protection.
// - Mode pin high selects PWM, low requests PFM.
// - Sleep input low ignores the mode pin and keeps the regulator shut down.
module buck_mode_ctrl #(
    parameter int ENTRY_CYCLES = `PFM_ENTRY_OSC_CYCLES,
    parameter int TMR_W = 8
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pins and comparators, asynchronous
    input wire logic sleep_n,
    input wire logic mode_pwm,
    input wire logic osc_clk,
    input wire logic fb_below,
    input wire logic pwm_reset_trip,
    input wire logic pfm_peak_trip,
    input wire logic ss_above_pfm_threshold,
    input wire logic output_good_flag,
    input wire logic [4:0] pfm_faults,
    // Power stage and bias control
    output logic hs_gate,
    output logic low_quiescent,
    output logic reduced_current,
    output logic fault_detect_enable,
    output logic thermal_shutdown_monitor,
    output buck_ctl_pkg::mode_e mode_state,
    // Interrupt
    output logic irq
);
    import buck_ctl_pkg::*;

    localparam int ENTRY_W = $clog2(ENTRY_CYCLES);
    localparam logic [ENTRY_W-1:0] ENTRY_LAST = ENTRY_W'(ENTRY_CYCLES - 1);
    localparam logic [TMR_W-1:0] WAKE_CYC = TMR_W'(`PFM_WAKE_CYC);
    localparam logic [TMR_W-1:0] ON_CYC = TMR_W'(`PFM_MAX_ON_CYC);
    localparam logic [TMR_W-1:0] OFF_CYC = TMR_W'(`PFM_OFF_CYC);

    initial begin
        if (ENTRY_CYCLES < 2) begin
            $error("buck_mode_ctrl: entry count must be at least two");
        end
        if (`PFM_WAKE_CYC >= (1 << TMR_W) || `PFM_MAX_ON_CYC >= (1 << TMR_W)
            || `PFM_OFF_CYC >= (1 << TMR_W)) begin
            $error("buck_mode_ctrl: timer too narrow for the delays");
        end
    end

    // Synchronised inputs and internal signals
    logic sleep_s, mode_s, osc_s, fb_s, prst_s, ppk_s, ss_s, good_s;
    logic [4:0] flt_s;
    logic osc_d;
    logic osc_edge;
    logic fault_any;
    logic in_pfm, in_pwm;
    logic entry_ok;
    logic [ENTRY_W-1:0] entry_cnt;
    mode_e state, next_state;
    logic tmr_load, tmr_expired;
    logic [TMR_W-1:0] tmr_val;
    logic pfm_allow;
    logic [`IRQ_W-1:0] irq_stat, irq_mask, irq_set;
    logic apb_done, rd_clear;

    // Every pin and comparator passes two flops before use
    sync_2ff #(.W(13)) u_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .async_in({sleep_n, mode_pwm, osc_clk, fb_below, pwm_reset_trip, pfm_peak_trip,
                   ss_above_pfm_threshold, output_good_flag, pfm_faults}),
        .sync_out({sleep_s, mode_s, osc_s, fb_s, prst_s, ppk_s, ss_s, good_s, flt_s})
    );

    // Oscillator edge detect on the synchronised level
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            osc_d <= 1'b0;
        end else begin
            osc_d <= osc_s;
        end
    end
    assign osc_edge = osc_s && !osc_d;

    // Fault detectors that stay alive in PFM feed the fallback
    assign fault_any = |flt_s;
    assign in_pfm = (state == ST_PFM_COAST) || (state == ST_PFM_WAKE)
                    || (state == ST_PFM_ON) || (state == ST_PFM_OFF);
    assign in_pwm = (state == ST_PWM) || (state == ST_LOWIP_PWM);
    // Low mode pin is a PFM request; only honoured when the output is settled
    assign entry_ok = !mode_s && ss_s && good_s && pfm_allow;

    // Entry filter: any break in the conditions restarts the count
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            entry_cnt <= '0;
        end else if (state != ST_PWM || !entry_ok) begin
            entry_cnt <= '0;
        end else if (osc_edge) begin
            entry_cnt <= entry_cnt + 1'b1;
        end
    end

    // Next operating state; sleep beats faults, faults beat the mode pin
    always_comb begin
        next_state = state;
        if (!sleep_s) begin
            next_state = ST_SHUTDOWN;
        end else if (in_pfm && fault_any) begin
            next_state = ST_LOWIP_PWM;
        end else if ((in_pfm || state == ST_LOWIP_PWM) && mode_s) begin
            next_state = ST_PWM;
        end else begin
            case (state)
                ST_SHUTDOWN: begin
                    next_state = ST_PWM;
                end
                ST_PWM: begin
                    if (entry_ok && osc_edge && entry_cnt == ENTRY_LAST) begin
                        next_state = ST_PFM_COAST;
                    end
                end
                ST_PFM_COAST: begin
                    if (fb_s) begin
                        next_state = ST_PFM_WAKE;
                    end
                end
                ST_PFM_WAKE: begin
                    if (tmr_expired) begin
                        next_state = ST_PFM_ON;
                    end
                end
                ST_PFM_ON: begin
                    if (ppk_s || tmr_expired) begin
                        next_state = ST_PFM_OFF;
                    end
                end
                ST_PFM_OFF: begin
                    if (tmr_expired) begin
                        next_state = fb_s ? ST_PFM_ON : ST_PFM_COAST;
                    end
                end
                ST_LOWIP_PWM: begin
                    next_state = ST_LOWIP_PWM;
                end
                default: begin
                    next_state = ST_SHUTDOWN;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state <= ST_SHUTDOWN;
        end else begin
            state <= next_state;
        end
    end

    // One shared timer: each PFM phase reloads it on entry
    assign tmr_load = (next_state != state);
    always_comb begin
        case (next_state)
            ST_PFM_WAKE: tmr_val = WAKE_CYC;
            ST_PFM_ON: tmr_val = ON_CYC;
            ST_PFM_OFF: tmr_val = OFF_CYC;
            default: tmr_val = '0;
        endcase
    end

    delay_timer #(.W(TMR_W)) u_timer (
        .clk_sys(clk_sys),
        .rst(rst),
        .load(tmr_load),
        .load_val(tmr_val),
        .expired(tmr_expired)
    );

    // High-side gate: reset-dominant latch in PWM, timed pulse in PFM.
    // The latch starts cleared on mode entry so a stale PFM pulse never leaks.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            hs_gate <= 1'b0;
        end else if (next_state == ST_PWM || next_state == ST_LOWIP_PWM) begin
            if (next_state != state) begin
                hs_gate <= 1'b0;
            end else if (prst_s) begin
                hs_gate <= 1'b0;
            end else if (osc_edge) begin
                hs_gate <= 1'b1;
            end
        end else begin
            hs_gate <= (next_state == ST_PFM_ON);
        end
    end

    // Bias and protection enables follow the state being entered
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            low_quiescent <= 1'b0;
            reduced_current <= 1'b0;
            fault_detect_enable <= 1'b0;
            thermal_shutdown_monitor <= 1'b0;
            mode_state <= ST_SHUTDOWN;
        end else begin
            low_quiescent <= (next_state == ST_PFM_COAST);
            reduced_current <= (next_state == ST_LOWIP_PWM);
            fault_detect_enable <= (next_state == ST_PWM)
                                   || (next_state == ST_LOWIP_PWM);
            thermal_shutdown_monitor <= (next_state == ST_PWM)
                                        || (next_state == ST_LOWIP_PWM);
            mode_state <= next_state;
        end
    end

    // APB: one wait cycle so read data and pready leave flops
    assign apb_done = psel && penable && pready;
    assign rd_clear = apb_done && !pwrite && paddr == `REG_IRQ_STAT;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pready <= 1'b0;
            prdata <= '0;
            pslverr <= 1'b0;
        end else if (psel && penable && !pready) begin
            pready <= 1'b1;
            pslverr <= !(paddr == `REG_CTRL || paddr == `REG_STATUS
                         || paddr == `REG_IRQ_STAT || paddr == `REG_IRQ_MASK);
            case (paddr)
                `REG_CTRL: prdata <= {31'h0, pfm_allow};
                `REG_STATUS: prdata <= {24'h0, mode_s, fault_any, low_quiescent,
                                        reduced_current, hs_gate, state};
                `REG_IRQ_STAT: prdata <= {28'h0, irq_stat};
                `REG_IRQ_MASK: prdata <= {28'h0, irq_mask};
                default: prdata <= '0;
            endcase
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end
    end

    // Writable registers take effect at the completing edge only
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pfm_allow <= `CTRL_RESET;
            irq_mask <= `IRQ_MASK_RESET;
        end else if (apb_done && pwrite) begin
            if (paddr == `REG_CTRL) begin
                pfm_allow <= pwdata[`CTRL_PFM_ALLOW];
            end
            if (paddr == `REG_IRQ_MASK) begin
                irq_mask <= pwdata[`IRQ_W-1:0];
            end
        end
    end

    // Sticky events; a new event beats the clear of a simultaneous read
    assign irq_set[`IRQ_PFM_ENTRY] = (state == ST_PWM) && (next_state == ST_PFM_COAST);
    assign irq_set[`IRQ_PFM_EXIT] = in_pfm && (next_state == ST_PWM);
    assign irq_set[`IRQ_FAULT_FALLBACK] = in_pfm && (next_state == ST_LOWIP_PWM);
    assign irq_set[`IRQ_PULSE_SKIP] = in_pwm && (next_state == state) && osc_edge && prst_s;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            irq_stat <= '0;
            irq <= 1'b0;
        end else begin
            irq_stat <= (rd_clear ? '0 : irq_stat) | irq_set;
            irq <= |(((rd_clear ? '0 : irq_stat) | irq_set) & irq_mask);
        end
    end

    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // Helper: cycles spent in the wake state
    logic [TMR_W-1:0] wake_cnt;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wake_cnt <= '0;
        end else if (state == ST_PFM_WAKE) begin
            wake_cnt <= wake_cnt + 1'b1;
        end else begin
            wake_cnt <= '0;
        end
    end

    sequence pulse_ends_s;
        state == ST_PFM_ON && sleep_s && !fault_any && !mode_s && (ppk_s || tmr_expired);
    endsequence
    sequence off_done_low_fb_s;
        state == ST_PFM_OFF && tmr_expired && sleep_s && !fault_any && !mode_s && fb_s;
    endsequence

    entry_count_a: assert property (
        (state == ST_PWM && next_state == ST_PFM_COAST)
        |-> entry_cnt == ENTRY_LAST && osc_edge && ss_s && good_s && !mode_s)
        else $error("PFM entered before the full oscillator count");
    coast_hold_a: assert property (
        (state == ST_PFM_COAST && sleep_s && !fb_s && !fault_any && !mode_s)
        |=> state == ST_PFM_COAST && low_quiescent && !hs_gate)
        else $error("coast left while feedback high");
    wake_delay_a: assert property (
        (state == ST_PFM_WAKE && next_state == ST_PFM_ON) |-> wake_cnt == WAKE_CYC - 1'b1)
        else $error("wake delay has wrong length");
    pulse_end_a: assert property (
        pulse_ends_s |=> !hs_gate && state == ST_PFM_OFF)
        else $error("PFM pulse not ended on limit");
    off_repeat_a: assert property (
        off_done_low_fb_s |=> state == ST_PFM_ON && hs_gate)
        else $error("no new pulse after off delay");
    latch_set_a: assert property (
        (state == ST_PWM && next_state == ST_PWM && osc_edge && !prst_s) |=> hs_gate)
        else $error("oscillator edge did not set latch");
    reset_dominant_a: assert property (
        (in_pwm && next_state == state && prst_s) |=> !hs_gate)
        else $error("latch set while reset active");
    pwm_protect_a: assert property (
        (state == ST_PWM) |-> fault_detect_enable && thermal_shutdown_monitor)
        else $error("fault detection off in PWM");
    fault_fallback_a: assert property (
        (in_pfm && fault_any && sleep_s) |=> state == ST_LOWIP_PWM ##0 reduced_current)
        else $error("PFM fault did not fall back");
    thermal_off_a: assert property (
        in_pfm |-> !thermal_shutdown_monitor)
        else $error("thermal monitor on in PFM");
    lowip_protect_a: assert property (
        (state == ST_LOWIP_PWM) |-> fault_detect_enable && thermal_shutdown_monitor
        && $past(state) != ST_SHUTDOWN && $past(state) != ST_PWM)
        else $error("reduced-current mode without PFM fault");
    sleep_shut_a: assert property (
        !sleep_s |=> state == ST_SHUTDOWN && !hs_gate)
        else $error("not shut down while asleep");
    resume_pwm_a: assert property (
        ((in_pfm || state == ST_LOWIP_PWM) && mode_s && sleep_s && !(in_pfm && fault_any))
        |=> state == ST_PWM && !reduced_current)
        else $error("mode pin high did not resume PWM");

endmodule

// File: bench/pin_ctrl_model.sv
// System controller model: drives the sleep and mode-select pins.
// Assumes the bench calls set_pins; pins change just after a rising edge.
module pin_ctrl_model (
    // Clock
    input wire logic clk_sys,
    // Pins towards the regulator
    output logic sleep_n,
    output logic mode_pwm
);
    timeunit 1ns;
    timeprecision 1ps;

    // Start awake in PWM so the first mode seen is the plain one
    initial begin
        sleep_n = 1'b1;
        mode_pwm = 1'b1;
    end

    // High selects PWM, low requests PFM; sleep low forces shutdown
    task set_pins(input logic s, input logic m);
        @(posedge clk_sys);
        sleep_n <= s;
        mode_pwm <= m;
    endtask
endmodule

// File: bench/buck_mode_ctrl_bench.sv
// Self-checking bench of the buck mode controller, with a state model.
// Assumes the design header and package; entry count shortened to four.
`include "buck_ctl_params.svh"
module buck_mode_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import buck_ctl_pkg::*;
    localparam int ENTRY = 4;
    localparam int WAKE = `PFM_WAKE_CYC;
    localparam int MAXON = `PFM_MAX_ON_CYC;
    localparam int OFF = `PFM_OFF_CYC;
    logic clk_sys = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, d;
    logic pready, pslverr, er, sleep_n, mode_pwm, osc_clk = 0, fb_below = 0;
    logic pwm_reset_trip = 0, pfm_peak_trip = 0, ss_above_pfm_threshold = 0;
    logic output_good_flag = 1, hs_gate, low_quiescent, reduced_current;
    logic fault_detect_enable, thermal_shutdown_monitor, irq, seen_hs = 0;
    logic [4:0] pfm_faults = 5'h00;
    mode_e mode_state;
    int mismatches = 0, cmp_count = 0, seed = 21523, n;

    always #10 clk_sys = ~clk_sys;
    // Catches even a one-cycle gate pulse that a skipped cycle must not show
    always @(negedge clk_sys) if (hs_gate === 1'b1) seen_hs <= 1'b1;

    pin_ctrl_model pins (.clk_sys(clk_sys), .sleep_n(sleep_n), .mode_pwm(mode_pwm));
    buck_mode_ctrl #(.ENTRY_CYCLES(ENTRY), .TMR_W(8)) dut (
        .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sleep_n(sleep_n), .mode_pwm(mode_pwm), .osc_clk(osc_clk),
        .fb_below(fb_below), .pwm_reset_trip(pwm_reset_trip),
        .pfm_peak_trip(pfm_peak_trip), .ss_above_pfm_threshold(ss_above_pfm_threshold),
        .output_good_flag(output_good_flag), .pfm_faults(pfm_faults), .hs_gate(hs_gate),
        .low_quiescent(low_quiescent), .reduced_current(reduced_current),
        .fault_detect_enable(fault_detect_enable),
        .thermal_shutdown_monitor(thermal_shutdown_monitor), .mode_state(mode_state),
        .irq(irq));

    task fail(input string m);
        mismatches++;
        $display("mismatch at %0t: %s", $time, m);
    endtask
    task give_verdict;
        $display("compares %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task chk_val(input logic [31:0] got, input logic [31:0] exp, input string m);
        cmp_count++;
        if (got !== exp) fail(m);
    endtask
    task chk_range(input int got, input int lo, input int hi, input string m);
        cmp_count++;
        if (got < lo || got > hi) fail(m);
    endtask
    // Model of the outputs that each state implies
    task chk_state(input mode_e e);
        logic fd;
        fd = (e == ST_PWM || e == ST_LOWIP_PWM);
        cmp_count++;
        if (mode_state !== e || low_quiescent !== (e == ST_PFM_COAST)
            || reduced_current !== (e == ST_LOWIP_PWM) || fault_detect_enable !== fd
            || thermal_shutdown_monitor !== fd) fail("state or bias outputs");
    endtask
    task cyc(input int k);
        repeat (k) @(posedge clk_sys);
    endtask
    task wait_state(input mode_e e, input int lim);
        int k;
        k = 0;
        while (mode_state !== e && k < lim) begin
            @(negedge clk_sys);
            k++;
        end
        chk_state(e);
    endtask
    task wait_hs(input logic v, output int k);
        k = 0;
        do begin
            @(negedge clk_sys);
            k++;
        end while (hs_gate !== v && k < 400);
    endtask
    task osc(input int k);
        repeat (k) begin
            cyc(1);
            osc_clk <= 1'b1;
            cyc(4);
            osc_clk <= 1'b0;
            cyc(3);
        end
    endtask
    // APB master: request held until pready is seen high at a rising edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
             output logic [31:0] r, output logic e);
        int k;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        k = 0;
        // Sample pready, data and error at the rising edge itself
        do begin
            @(posedge clk_sys);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) fail("apb timeout");
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    initial begin
        #400000;
        fail("watchdog");
        give_verdict;
    end

    initial begin
        cyc(16);
        rst <= 1'b0;
        wait_state(ST_PWM, 10);
        apb(0, `REG_CTRL, 32'h0, rd, er);
        chk_val(rd, 32'h1, "ctrl reset value");
        apb(0, `REG_IRQ_MASK, 32'h0, rd, er);
        chk_val(rd, 32'h0, "mask reset value");
        d = $random(seed);
        apb(1, `REG_IRQ_MASK, d, rd, er);
        apb(0, `REG_IRQ_MASK, 32'h0, rd, er);
        chk_val(rd, {28'h0, d[3:0]}, "mask readback");
        apb(0, 8'h10, 32'h0, rd, er);
        chk_val({31'h0, er}, 32'h1, "unmapped error");
        chk_val(rd, 32'h0, "unmapped data");
        $display("test registers done");
        // Fixed-frequency cycle, then a skipped cycle under a held reset
        apb(1, `REG_IRQ_MASK, 32'h8, rd, er);
        osc(1);
        chk_val(hs_gate, 1, "latch not set");
        chk_state(ST_PWM);
        pwm_reset_trip <= 1'b1;
        cyc(5);
        chk_val(hs_gate, 0, "latch not reset");
        seen_hs = 1'b0;
        osc(1);
        chk_val(seen_hs, 0, "edge passed a held reset");
        chk_val(irq, 1, "skip interrupt");
        apb(0, `REG_IRQ_STAT, 32'h0, rd, er);
        chk_val(rd, 32'h8, "skip status");
        cyc(2);
        chk_val(irq, 0, "interrupt after clear");
        pwm_reset_trip <= 1'b0;
        $display("test pwm done");
        // Entry count restarts while soft-start is low
        pins.set_pins(1'b1, 1'b0);
        osc(ENTRY + 2);
        chk_state(ST_PWM);
        ss_above_pfm_threshold <= 1'b1;
        cyc(4);
        osc(ENTRY - 1);
        chk_state(ST_PWM);
        osc(1);
        wait_state(ST_PFM_COAST, 6);
        chk_val(hs_gate, 0, "switching in coast");
        // Burst: wake, on-time limit, off delay, peak trip, back to coast
        fb_below <= 1'b1;
        wait_hs(1, n);
        chk_range(n, WAKE, WAKE + 8, "wake delay");
        wait_hs(0, n);
        chk_range(n, MAXON - 2, MAXON + 2, "max on-time");
        wait_hs(1, n);
        chk_range(n, OFF - 1, OFF + 3, "off delay");
        cyc(10);
        pfm_peak_trip <= 1'b1;
        wait_hs(0, n);
        chk_range(n, 1, 5, "peak trip");
        cyc(1);
        pfm_peak_trip <= 1'b0;
        fb_below <= 1'b0;
        wait_state(ST_PFM_COAST, OFF + 10);
        $display("test pfm done");
        // Any fault in PFM falls back to reduced-current PWM
        d = $random(seed);
        if (d[4:0] == 5'h00) d = 32'h1;
        cyc(1);
        pfm_faults <= d[4:0];
        wait_state(ST_LOWIP_PWM, 6);
        apb(0, `REG_IRQ_STAT, 32'h0, rd, er);
        chk_val(rd & 32'h5, 32'h5, "entry and fallback status");
        pfm_faults <= 5'h00;
        pins.set_pins(1'b1, 1'b1);
        wait_state(ST_PWM, 6);
        pins.set_pins(1'b0, 1'b0);
        wait_state(ST_SHUTDOWN, 6);
        osc(ENTRY + 2);
        chk_state(ST_SHUTDOWN);
        chk_val(hs_gate, 0, "switching in shutdown");
        $display("test faults and sleep done");
        // Wake again; pfm_allow and output good each block entry
        pins.set_pins(1'b1, 1'b0);
        wait_state(ST_PWM, 6);
        apb(1, `REG_CTRL, 32'h0, rd, er);
        osc(ENTRY + 2);
        chk_state(ST_PWM);
        apb(1, `REG_CTRL, 32'h1, rd, er);
        output_good_flag <= 1'b0;
        osc(ENTRY + 2);
        chk_state(ST_PWM);
        output_good_flag <= 1'b1;
        cyc(4);
        osc(ENTRY);
        wait_state(ST_PFM_COAST, 6);
        apb(0, `REG_STATUS, 32'h0, rd, er);
        chk_val(rd, 32'h22, "coast status");
        // Mode pin high straight out of PFM
        pins.set_pins(1'b1, 1'b1);
        wait_state(ST_PWM, 6);
        apb(0, `REG_IRQ_STAT, 32'h0, rd, er);
        chk_val(rd, 32'h3, "entry and exit status");
        $display("test mode exits done");
        give_verdict;
    end
endmodule
